// ==== rtl/brownout_map.svh ====
`ifndef BROWNOUT_MAP_SVH
`define BROWNOUT_MAP_SVH

// register byte offsets
`define ADDR_RESET_CONTROL 6'h00
`define ADDR_IRQ_STATUS 6'h04
`define ADDR_IRQ_MASK 6'h08
`define ADDR_CONFIG_VIEW 6'h0c

// reset control register fields
`define FLD_SW_ENABLE 13
`define FLD_BOR_FLAG 1
`define FLD_POR_FLAG 0

// configuration field encodings
`define MODE_SOFTWARE 2'h1
`define MODE_SLEEP_OFF 2'h2
`define MODE_ALWAYS_ON 2'h3

// interrupt status bits
`define IRQ_BOR 0
`define IRQ_POR 1

// reset values
`define RST_CONTROL 32'h00000001
`define RST_MASK 2'h0

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/brownout_pkg.sv ====
package brownout_pkg;

  typedef struct packed {
    logic awvalid;
    logic [5:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [5:0] araddr;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef enum logic [1:0] {
    BOR_OFF = 2'b00,
    BOR_ARMED = 2'b01
  } bor_state_type;

endpackage

// ==== rtl/brownout_enable_logic.sv ====
`timescale 1ns/100ps
`include "brownout_map.svh"

module brownout_enable_logic (
  // configuration
  input wire logic [1:0] brownoutConfigMode,
  input wire logic softwareBrownoutEnable,
  input wire logic sleepActive,
  // result
  output logic detectEnable
);

  always_comb begin
    case (brownoutConfigMode)
      `MODE_SOFTWARE: detectEnable = softwareBrownoutEnable;
      `MODE_SLEEP_OFF: detectEnable = ~sleepActive;
      `MODE_ALWAYS_ON: detectEnable = 1'b1;
      default: detectEnable = 1'b0;
    endcase
  end

endmodule

// ==== rtl/brownout_reset_control.sv ====
// Summary of operation
// - mode 01 lets bit 13 gate detection
// - software bit fully enables or disables
// - software bit ignored, reads 0 otherwise
// - trip level only from configuration bits
// - enabled detector sets brown-out flag always
// - software zeros hold until next event
// - mode 10 disables detection in sleep
// - leaving sleep re-enables detection automatically
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "brownout_map.svh"

module brownout_reset_control (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // configuration and status
  input wire logic [1:0] brownoutConfigMode,
  input wire logic [1:0] brownoutLevelSelect,
  input wire logic sleepActive,
  input wire logic brownoutEvent,
  input wire logic powerOnEvent,
  // axi4-lite
  input wire brownout_pkg::axi_req_type axiReq,
  output brownout_pkg::axi_rsp_type axiRsp,
  // detector control
  output logic detectEnable,
  output logic [1:0] tripLevel,
  output logic irq
);

  ////////////////////////////////////////////////////////////////
  logic swEnable_ff, nxt_swEnable;
  logic borFlag_ff, nxt_borFlag;
  logic porFlag_ff, nxt_porFlag;
  logic [1:0] irqStatus_ff, nxt_irqStatus;
  logic [1:0] irqMask_ff, nxt_irqMask;
  logic detectEnable_ff, nxt_detectEnable;
  logic [1:0] tripLevel_ff;
  logic irq_ff, nxt_irq;
  brownout_pkg::axi_rsp_type rsp_ff, nxt_rsp;
  brownout_pkg::bor_state_type state_ff, nxt_state;
  logic awHeld_ff, nxt_awHeld;
  logic wHeld_ff, nxt_wHeld;
  logic [5:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic detectComb, swMode, wrFire, rdFire, borHit, porHit;

  function automatic logic [31:0] readValue(input logic [5:0] addr, input logic [31:0] ctl,
                                             input logic [1:0] sts, input logic [1:0] msk,
                                             input logic [1:0] cfg, input logic [1:0] lvl);
    logic [31:0] v;
    v = 32'h00000000;
    if (addr == `ADDR_RESET_CONTROL) begin
      v = ctl;
    end else if (addr == `ADDR_IRQ_STATUS) begin
      v[1:0] = sts;
    end else if (addr == `ADDR_IRQ_MASK) begin
      v[1:0] = msk;
    end else if (addr == `ADDR_CONFIG_VIEW) begin
      v[3:0] = {lvl, cfg};
    end
    return v;
  endfunction

  function automatic logic addrHit(input logic [5:0] addr);
    return addr == `ADDR_RESET_CONTROL || addr == `ADDR_IRQ_STATUS ||
           addr == `ADDR_IRQ_MASK || addr == `ADDR_CONFIG_VIEW;
  endfunction

  ////////////////////////////////////////////////////////////////
  brownout_enable_logic u_enable (
    .brownoutConfigMode(brownoutConfigMode),
    .softwareBrownoutEnable(swEnable_ff),
    .sleepActive(sleepActive),
    .detectEnable(detectComb)
  );

  assign swMode = brownoutConfigMode == `MODE_SOFTWARE;
  // only an enabled detector can report a brown-out
  assign borHit = brownoutEvent & detectEnable_ff;
  assign porHit = powerOnEvent;

  ////////////////////////////////////////////////////////////////
  // write and read paths: write address and data accepted in either order
  always_comb begin
    nxt_rsp = rsp_ff;
    nxt_awHeld = awHeld_ff;
    nxt_wHeld = wHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_rsp.awready = 1'b0;
    nxt_rsp.wready = 1'b0;
    nxt_rsp.arready = 1'b0;
    wrFire = 1'b0;
    rdFire = 1'b0;
    if (axiReq.awvalid && !awHeld_ff && !rsp_ff.awready && !rsp_ff.bvalid) begin
      nxt_rsp.awready = 1'b1;
      nxt_awHeld = 1'b1;
      nxt_awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !wHeld_ff && !rsp_ff.wready && !rsp_ff.bvalid) begin
      nxt_rsp.wready = 1'b1;
      nxt_wHeld = 1'b1;
      nxt_wData = axiReq.wdata;
      nxt_wStrb = axiReq.wstrb;
    end
    if (awHeld_ff && wHeld_ff && !rsp_ff.bvalid) begin
      wrFire = 1'b1;
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_rsp.bvalid = 1'b1;
      nxt_rsp.bresp = addrHit(awAddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rsp_ff.bvalid && axiReq.bready) begin
      nxt_rsp.bvalid = 1'b0;
    end
    if (axiReq.arvalid && !rsp_ff.arready && !rsp_ff.rvalid) begin
      rdFire = 1'b1;
      nxt_rsp.arready = 1'b1;
      nxt_rsp.rvalid = 1'b1;
      nxt_rsp.rresp = addrHit(axiReq.araddr) ? `RESP_OKAY : `RESP_SLVERR;
      nxt_rsp.rdata = readValue(axiReq.araddr,
                                {18'h00000, swEnable_ff & swMode, 11'h000, borFlag_ff, porFlag_ff},
                                irqStatus_ff, irqMask_ff, brownoutConfigMode, brownoutLevelSelect);
    end else if (rsp_ff.rvalid && axiReq.rready) begin
      nxt_rsp.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register state
  always_comb begin
    nxt_swEnable = swEnable_ff;
    nxt_borFlag = borFlag_ff;
    nxt_porFlag = porFlag_ff;
    nxt_irqStatus = irqStatus_ff;
    nxt_irqMask = irqMask_ff;
    if (wrFire && awAddr_ff == `ADDR_RESET_CONTROL) begin
      if (wStrb_ff[1]) begin
        if (swMode) begin
          nxt_swEnable = wData_ff[`FLD_SW_ENABLE];
        end
      end
      if (wStrb_ff[0]) begin
        nxt_borFlag = wData_ff[`FLD_BOR_FLAG];
        nxt_porFlag = wData_ff[`FLD_POR_FLAG];
      end
    end
    if (wrFire && awAddr_ff == `ADDR_IRQ_MASK && wStrb_ff[0]) begin
      nxt_irqMask = wData_ff[1:0];
    end
    // read clears status; a same-cycle event still wins below
    if (rdFire && axiReq.araddr == `ADDR_IRQ_STATUS) begin
      nxt_irqStatus = 2'h0;
    end
    // set on brown-out or power-on while enabled
    if (borHit || (porHit && detectEnable_ff)) begin
      nxt_borFlag = 1'b1;
    end
    if (porHit) begin
      nxt_porFlag = 1'b1;
    end
    if (borHit) begin
      nxt_irqStatus[`IRQ_BOR] = 1'b1;
    end
    if (porHit) begin
      nxt_irqStatus[`IRQ_POR] = 1'b1;
    end
    nxt_irq = |(nxt_irqStatus & nxt_irqMask);
    nxt_detectEnable = detectComb;
    nxt_state = detectComb ? brownout_pkg::BOR_ARMED : brownout_pkg::BOR_OFF;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      swEnable_ff <= 1'b0;
      borFlag_ff <= 1'b0;
      porFlag_ff <= 1'b1;
      irqStatus_ff <= 2'h0;
      irqMask_ff <= `RST_MASK;
      detectEnable_ff <= 1'b0;
      tripLevel_ff <= 2'h0;
      irq_ff <= 1'b0;
      rsp_ff <= '0;
      state_ff <= brownout_pkg::BOR_OFF;
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 6'h00;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else begin
      swEnable_ff <= nxt_swEnable;
      borFlag_ff <= nxt_borFlag;
      porFlag_ff <= nxt_porFlag;
      irqStatus_ff <= nxt_irqStatus;
      irqMask_ff <= nxt_irqMask;
      detectEnable_ff <= nxt_detectEnable;
      tripLevel_ff <= brownoutLevelSelect;
      irq_ff <= nxt_irq;
      rsp_ff <= nxt_rsp;
      state_ff <= nxt_state;
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
    end
  end

  assign axiRsp = rsp_ff;
  assign detectEnable = detectEnable_ff;
  assign tripLevel = tripLevel_ff;
  assign irq = irq_ff;

endmodule

// ==== dv/brownout_reset_control_assertions.sv ====
`timescale 1ns/100ps
module brownout_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // inputs
  input wire logic [1:0] brownoutConfigMode,
  input wire logic [1:0] brownoutLevelSelect,
  input wire logic sleepActive,
  input wire logic brownoutEvent,
  input wire logic powerOnEvent,
  input wire brownout_pkg::axi_req_type axiReq,
  // outputs
  input wire brownout_pkg::axi_rsp_type axiRsp,
  input wire logic detectEnable,
  input wire logic [1:0] tripLevel,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence sWake;
    brownoutConfigMode == 2'h2 && $fell(sleepActive);
  endsequence
  // no write in flight, so the enable bit cannot move
  sequence sQuiet;
    (brownoutConfigMode == 2'h1 && !axiReq.awvalid && !axiRsp.bvalid) [*3];
  endsequence
  sequence sCtlRead;
    axiRsp.rvalid && axiReq.arvalid && axiReq.araddr == 6'h00;
  endsequence
  AST_MODE_OFF: assert property (brownoutConfigMode == 2'h0 |=> !detectEnable)
    else $error("detector on in mode 00");
  AST_ALWAYS_ON: assert property (brownoutConfigMode == 2'h3 |=> detectEnable)
    else $error("detector off in mode 11");
  AST_SLEEP_OFF: assert property (brownoutConfigMode == 2'h2 && sleepActive |=> !detectEnable)
    else $error("detector on in sleep");
  AST_WAKE: assert property (sWake |=> detectEnable)
    else $error("detector not back after sleep");
  AST_LEVEL: assert property (1'b1 |=> tripLevel == $past(brownoutLevelSelect))
    else $error("trip level not from level select");
  AST_SW_STEADY: assert property (sQuiet |-> $stable(detectEnable))
    else $error("detector moved without a write");
  AST_SW_READ0: assert property (sCtlRead ##0 brownoutConfigMode != 2'h1 |-> !axiRsp.rdata[13])
    else $error("enable bit reads 1 outside mode 01");
  AST_SW_MATCH: assert property (sCtlRead ##0 brownoutConfigMode == 2'h1 && $past(brownoutConfigMode) == 2'h1
    |-> axiRsp.rdata[13] == detectEnable)
    else $error("enable bit and detector differ");
endmodule
bind brownout_reset_control brownout_checker u_chk (.mclk, .arst_n, .brownoutConfigMode, .brownoutLevelSelect,
  .sleepActive, .brownoutEvent, .powerOnEvent, .axiReq, .axiRsp, .detectEnable, .tripLevel, .irq);

// ==== dv/brownout_reset_control_tb_top.sv ====
`timescale 1ns/100ps
module brownout_reset_control_tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] lvl = 2'h0;
  logic sleep = 1'b0;
  logic bev = 1'b0;
  logic pev = 1'b0;
  brownout_pkg::axi_req_type req = '0;
  brownout_pkg::axi_rsp_type rsp;
  logic detEn;
  logic [1:0] trip;
  logic irq;
  logic [65:0] expQ [$];
  logic [65:0] e;
  logic [31:0] rng = 32'h00004b80;
  int n_mismatch = 0;
  int tests_run = 0;
  brownout_reset_control u_dut (.mclk, .arst_n, .brownoutConfigMode(mode), .brownoutLevelSelect(lvl),
    .sleepActive(sleep), .brownoutEvent(bev), .powerOnEvent(pev), .axiReq(req), .axiRsp(rsp),
    .detectEnable(detEn), .tripLevel(trip), .irq);
  initial begin
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // level select wanders at random; trip level must track it
  always @(posedge mclk) begin
    rng <= xs(rng);
    lvl <= rng[1:0];
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge mclk) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      e = expQ.pop_front();
      check(rsp.rdata & e[63:32], e[31:0]);
      // unmapped read answers with an error response
      check({30'h0, rsp.rresp}, {30'h0, e[65:64]});
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    // unmapped write answers with an error response
    check({30'h0, rsp.bresp}, {30'h0, (a > 6'h0c) ? 2'h2 : 2'h0});
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
    @(posedge mclk);
    expQ.push_back({(a > 6'h0c) ? 2'h2 : 2'h0, m, x & m});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask
  task automatic pulse(input logic p);
    @(posedge mclk);
    pev <= p;
    bev <= !p;
    @(posedge mclk);
    pev <= 1'b0;
    bev <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    rd(6'h00, 32'h1);
    wr(6'h00, 32'h0);
    rd(6'h00, 32'h0);
    pulse(1'b0);
    rd(6'h00, 32'h0);
    mode <= 2'h3;
    pulse(1'b0);
    rd(6'h00, 32'h2);
    wr(6'h00, 32'h0);
    pulse(1'b1);
    rd(6'h00, 32'h3);
    wr(6'h00, 32'h2000);
    rd(6'h00, 32'h0);
    mode <= 2'h1;
    wr(6'h00, 32'h2000);
    rd(6'h00, 32'h2000);
    pulse(1'b0);
    rd(6'h00, 32'h2002);
    wr(6'h00, 32'h0);
    pulse(1'b0);
    rd(6'h00, 32'h0);
    mode <= 2'h2;
    sleep <= 1'b1;
    pulse(1'b0);
    rd(6'h00, 32'h0);
    sleep <= 1'b0;
    pulse(1'b0);
    rd(6'h00, 32'h2);
    rd(6'h10, 32'h0);
    wr(6'h10, 32'h3);
    rd(6'h00, 32'h2);
    // status holds history of earlier events, so clear it unchecked
    rd(6'h04, 32'h0, 32'h0);
    wr(6'h08, 32'h2);
    pulse(1'b1);
    #1;
    check({31'h0, irq}, 32'h1);
    rd(6'h04, 32'h2, 32'h2);
    repeat (2) @(posedge mclk);
    #1;
    check({31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule
